// *** cedc_pkg.sv ***
// constants, encodings and helpers shared by the console examine/deposit checker
package cedc_pkg;

  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int DIG_W = 24;
  localparam int DDIG_W = 18;
  localparam int UADDR_W = 8;

  localparam logic [3:0] MAX_DIGITS = 4'h8;
  localparam logic [2:0] MAX_DATA_DIGITS = 3'h6;

  localparam logic [23:0] GREG_MAX = 24'h00000f;
  localparam logic [23:0] MREG_MAX = 24'h000009;
  localparam logic [23:0] MREG_WRITABLE = 24'h000004;
  localparam logic [23:0] VIRT_MAX = 24'h00ffff;
  localparam logic [23:0] BKPT_BAD_PHYS = 24'h000000;
  localparam logic [17:0] DATA_MAX = 18'h0ffff;
  localparam logic [15:0] FILL_MAX = 16'h00ff;

  localparam logic [23:0] SWITCH_ADDR = 24'h3fff78;
  localparam logic [23:0] PSTAT_ADDR = 24'h3ffffe;
  localparam logic [23:0] PC_IDX = 24'h000007;
  localparam logic [23:0] KSTACK_IDX = 24'h000006;
  localparam logic [23:0] SSTACK_IDX = 24'h00000e;
  localparam logic [23:0] USTACK_IDX = 24'h00000f;
  localparam logic [23:0] MEM_STEP = 24'h000002;
  localparam logic [23:0] REG_STEP = 24'h000001;

  localparam logic [7:0] MICRO_BUSY_ADDR = 8'h0d;

  localparam int STOP_WAIT_US = 500;
  localparam int CLK_MHZ = 200;
  localparam int STOP_WAIT_CYC = STOP_WAIT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    CMD_EXAMINE, CMD_DEPOSIT, CMD_BKPT, CMD_HALT, CMD_FILL
  } cedc_cmd_t;

  typedef enum logic [3:0] {
    ARG_OCTAL, ARG_LAST, ARG_INDIRECT, ARG_NEXT, ARG_PREV, ARG_GREG, ARG_MREG,
    ARG_SWITCH, ARG_PSTAT, ARG_PC, ARG_KSTACK, ARG_SSTACK, ARG_USTACK
  } cedc_arg_t;

  typedef enum logic [1:0] {SP_PHYS, SP_VIRT, SP_GREG, SP_MREG} cedc_space_t;

  typedef enum logic [3:0] {
    ERR_NONE, ERR_SYNTAX, ERR_MUST_STOP, ERR_BAD_BKPT, ERR_MICRO_STATE, ERR_TOO_BIG,
    ERR_ACCESS_ABORTED, ERR_READ_ONLY, ERR_STOP_TIMEOUT, ERR_ALREADY_HALTED,
    ERR_UNCERTAIN, ERR_PARITY, ERR_STUCK
  } cedc_err_t;

  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_XFER, S_HALT} cedc_state_t;

  // keeps only the low n octal digits
  function automatic logic [23:0] cedc_digit_mask(input logic [3:0] n);
    logic [23:0] m;
    m = 24'h000000;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(n)) begin
        m[3*i +: 3] = 3'h7;
      end
    end
    return m;
  endfunction

endpackage

// *** cedc_timer.sv ***
// restartable one-shot timeout counter
`timescale 1ns/1ps
module cedc_timer #(
  parameter int CYCLES = 100000
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic start,
  input wire logic stop,
  // result
  output logic expired
);
  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;
  logic run_ff;
  wire last_tick = (cnt_ff == CW'(CYCLES - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= run_ff && last_tick && !stop && !start;
      if (start) begin
        run_ff <= 1'b1;
        cnt_ff <= '0;
      end else if (stop || last_tick) begin
        run_ff <= 1'b0;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end
endmodule

// *** cedc_top.sv ***
// console examine/deposit argument resolver and request checker
`timescale 1ns/1ps
// Notes on behaviour
// - numeric address argument takes one to eight octal digits.
// - asterisk argument reuses the previous address unchanged.
// - at-sign argument uses the last examined data as address.
// - general register above 17 or machine register above 11 octal is too big.
// - only machine register 4 is writable; other deposits give read-only error.
// - switch word alias resolves to physical 17777570.
// - processor status alias resolves to physical 17777776.
// - program counter 7, kernel stack 6, supervisor stack 16, user stack 17.
// - stop-needing commands refused with must-stop error while processor runs.
// - breakpoint refused at physical 0 or on any register.
// - breakpoint refused while microcode counter sits at 015.
// - virtual address above 177777 is too big.
// - fill count above 377 octal is too big.
// - unmapped virtual address aborts the access.
// - deposit to read-only page is done, with a warning only.
// - halt not done within 500 us gives stop timeout error.
// - halt request while already stopped gives already-halted error.
// - examine not answered within 500 us reports uncertain run state.
// - parity enabled and bad parity on read reports parity error.
// - addresses zero-extend to 22 bits, data to 16 bits.
// - stuck address/data lines report their own error.
module cedc_top #(
  parameter int STOP_WAIT_CYCLES = cedc_pkg::STOP_WAIT_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic ARST_N,
  // parsed command from the terminal side
  input wire logic REQ_VALID,
  input wire cedc_pkg::cedc_cmd_t REQ_CMD,
  input wire cedc_pkg::cedc_arg_t REQ_ARG,
  input wire logic [23:0] REQ_DIGITS,
  input wire logic [3:0] REQ_NDIG,
  input wire logic REQ_VIRT,
  input wire logic [17:0] REQ_DATA_DIGITS,
  input wire logic [2:0] REQ_DATA_NDIG,
  input wire logic [15:0] REQ_COUNT,
  // answer to the terminal side
  output logic BUSY,
  output logic DONE,
  output cedc_pkg::cedc_err_t ERR_CODE,
  output logic WARN_RO,
  output logic [21:0] RES_ADDR,
  output cedc_pkg::cedc_space_t RES_SPACE,
  output logic [15:0] RD_DATA,
  // processor state
  input wire logic CPU_RUNNING,
  input wire logic [7:0] CPU_UADDR,
  input wire logic PAR_EN,
  input wire logic MAP_VALID,
  input wire logic PAGE_RO,
  // processor halt and access path
  output logic HALT_REQ,
  output logic XFER_REQ,
  output logic XFER_WRITE,
  output logic [15:0] XFER_WDATA,
  input wire logic XFER_ACK,
  input wire logic [15:0] XFER_RDATA,
  input wire logic XFER_PAR_BAD,
  input wire logic XFER_STUCK
);

  cedc_pkg::cedc_state_t state_ff, nxt_state;
  cedc_pkg::cedc_cmd_t cmd_ff, nxt_cmd;
  cedc_pkg::cedc_space_t last_space_ff, nxt_last_space, nxt_space;
  cedc_pkg::cedc_err_t nxt_err;
  logic [21:0] last_addr_ff, nxt_last_addr, nxt_addr;
  logic [15:0] last_data_ff, nxt_last_data, nxt_rdata, nxt_wdata;
  logic [7:0] cnt_ff, nxt_cnt;
  logic nxt_done, nxt_warn, nxt_xreq, nxt_write, nxt_halt;
  logic tmr_start, tmr_stop, tmr_expired;
  logic [23:0] req_addr;
  cedc_pkg::cedc_space_t req_space;

  // argument decode
  wire acc = REQ_VALID && (state_ff == cedc_pkg::S_IDLE);
  wire [23:0] dig_val = REQ_DIGITS & cedc_pkg::cedc_digit_mask(REQ_NDIG);
  wire [23:0] data_mask = cedc_pkg::cedc_digit_mask({1'b0, REQ_DATA_NDIG});
  wire [17:0] data_val = REQ_DATA_DIGITS & data_mask[17:0];
  wire req_write = (REQ_CMD == cedc_pkg::CMD_DEPOSIT) || (REQ_CMD == cedc_pkg::CMD_FILL);
  wire needs_digits = (REQ_ARG == cedc_pkg::ARG_OCTAL) || (REQ_ARG == cedc_pkg::ARG_GREG) ||
    (REQ_ARG == cedc_pkg::ARG_MREG);
  wire addr_syntax_bad = needs_digits &&
    ((REQ_NDIG == 4'h0) || (REQ_NDIG > cedc_pkg::MAX_DIGITS));
  wire data_syntax_bad = req_write && (REQ_DATA_NDIG > cedc_pkg::MAX_DATA_DIGITS);
  wire syntax_bad = addr_syntax_bad || data_syntax_bad;
  wire data_big = req_write && (data_val > cedc_pkg::DATA_MAX);

  // register index steps by one, memory by a word
  wire [23:0] last_step = ((last_space_ff == cedc_pkg::SP_GREG) ||
    (last_space_ff == cedc_pkg::SP_MREG)) ? cedc_pkg::REG_STEP : cedc_pkg::MEM_STEP;
  wire [23:0] last_wide = {2'b00, last_addr_ff};
  wire cpu_mem = REQ_VIRT ? 1'b1 : 1'b0;

  always_comb begin
    req_space = cpu_mem ? cedc_pkg::SP_VIRT : cedc_pkg::SP_PHYS;
    req_addr = dig_val;
    unique case (REQ_ARG)
      cedc_pkg::ARG_OCTAL: req_addr = dig_val;
      cedc_pkg::ARG_LAST: begin
        req_addr = last_wide;
        req_space = last_space_ff;
      end
      cedc_pkg::ARG_INDIRECT: req_addr = {8'h00, last_data_ff};
      cedc_pkg::ARG_NEXT: begin
        req_addr = 24'(last_wide + last_step);
        req_space = last_space_ff;
      end
      cedc_pkg::ARG_PREV: begin
        req_addr = 24'(last_wide - last_step);
        req_space = last_space_ff;
      end
      cedc_pkg::ARG_GREG: req_space = cedc_pkg::SP_GREG;
      cedc_pkg::ARG_MREG: req_space = cedc_pkg::SP_MREG;
      cedc_pkg::ARG_SWITCH: begin
        req_addr = cedc_pkg::SWITCH_ADDR;
        req_space = cedc_pkg::SP_PHYS;
      end
      cedc_pkg::ARG_PSTAT: begin
        req_addr = cedc_pkg::PSTAT_ADDR;
        req_space = cedc_pkg::SP_PHYS;
      end
      cedc_pkg::ARG_PC: begin
        req_addr = cedc_pkg::PC_IDX;
        req_space = cedc_pkg::SP_GREG;
      end
      cedc_pkg::ARG_KSTACK: begin
        req_addr = cedc_pkg::KSTACK_IDX;
        req_space = cedc_pkg::SP_GREG;
      end
      cedc_pkg::ARG_SSTACK: begin
        req_addr = cedc_pkg::SSTACK_IDX;
        req_space = cedc_pkg::SP_GREG;
      end
      cedc_pkg::ARG_USTACK: begin
        req_addr = cedc_pkg::USTACK_IDX;
        req_space = cedc_pkg::SP_GREG;
      end
      default: req_addr = dig_val;
    endcase
  end

  // early checks, first match wins
  wire is_bkpt = (REQ_CMD == cedc_pkg::CMD_BKPT);
  wire stop_needed = !is_bkpt && CPU_RUNNING;
  wire reg_big = ((req_space == cedc_pkg::SP_GREG) && (req_addr > cedc_pkg::GREG_MAX)) ||
    ((req_space == cedc_pkg::SP_MREG) && (req_addr > cedc_pkg::MREG_MAX));
  wire virt_big = (req_space == cedc_pkg::SP_VIRT) && (req_addr > cedc_pkg::VIRT_MAX);
  wire phys_big = (req_space == cedc_pkg::SP_PHYS) && (req_addr[23:22] != 2'b00);
  wire fill_big = (REQ_CMD == cedc_pkg::CMD_FILL) && (REQ_COUNT > cedc_pkg::FILL_MAX);
  wire too_big = reg_big || virt_big || phys_big || fill_big || data_big;
  wire bkpt_bad = is_bkpt && ((req_space == cedc_pkg::SP_GREG) ||
    (req_space == cedc_pkg::SP_MREG) ||
    ((req_space == cedc_pkg::SP_PHYS) && (req_addr == cedc_pkg::BKPT_BAD_PHYS)));
  wire micro_busy = is_bkpt && (CPU_UADDR == cedc_pkg::MICRO_BUSY_ADDR);
  wire mreg_ro = req_write && (req_space == cedc_pkg::SP_MREG) &&
    (req_addr != cedc_pkg::MREG_WRITABLE);
  cedc_pkg::cedc_err_t early_err;
  assign early_err = syntax_bad ? cedc_pkg::ERR_SYNTAX :
    stop_needed ? cedc_pkg::ERR_MUST_STOP :
    too_big ? cedc_pkg::ERR_TOO_BIG :
    bkpt_bad ? cedc_pkg::ERR_BAD_BKPT :
    micro_busy ? cedc_pkg::ERR_MICRO_STATE :
    mreg_ro ? cedc_pkg::ERR_READ_ONLY : cedc_pkg::ERR_NONE;

  wire unmapped = (RES_SPACE == cedc_pkg::SP_VIRT) && !MAP_VALID;
  wire ro_page = XFER_WRITE && (RES_SPACE == cedc_pkg::SP_VIRT) && PAGE_RO;
  wire par_fault = !XFER_WRITE && PAR_EN && XFER_PAR_BAD;
  wire fill_more = (cmd_ff == cedc_pkg::CMD_FILL) && (cnt_ff > 8'h01);

  always_comb begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = RES_ADDR;
    nxt_space = RES_SPACE;
    nxt_wdata = XFER_WDATA;
    nxt_write = XFER_WRITE;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    nxt_err = ERR_CODE;
    nxt_warn = WARN_RO;
    nxt_xreq = XFER_REQ;
    nxt_halt = HALT_REQ;
    nxt_rdata = RD_DATA;
    nxt_last_addr = last_addr_ff;
    nxt_last_space = last_space_ff;
    nxt_last_data = last_data_ff;
    tmr_start = 1'b0;
    tmr_stop = 1'b0;
    unique case (state_ff)
      cedc_pkg::S_IDLE: begin
        if (REQ_VALID) begin
          nxt_cmd = REQ_CMD;
          nxt_addr = req_addr[21:0];
          nxt_space = req_space;
          nxt_wdata = data_val[15:0];
          nxt_write = req_write;
          nxt_cnt = (REQ_CMD == cedc_pkg::CMD_FILL && REQ_COUNT[7:0] != 8'h00) ?
            REQ_COUNT[7:0] : 8'h01;
          nxt_warn = 1'b0;
          if (REQ_CMD == cedc_pkg::CMD_HALT) begin
            if (!CPU_RUNNING) begin
              nxt_done = 1'b1;
              nxt_err = cedc_pkg::ERR_ALREADY_HALTED;
            end else begin
              nxt_halt = 1'b1;
              tmr_start = 1'b1;
              nxt_state = cedc_pkg::S_HALT;
            end
          end else if (early_err != cedc_pkg::ERR_NONE) begin
            nxt_done = 1'b1;
            nxt_err = early_err;
          end else begin
            nxt_state = cedc_pkg::S_CHECK;
          end
        end
      end
      cedc_pkg::S_CHECK: begin
        if (unmapped) begin
          nxt_done = 1'b1;
          nxt_err = cedc_pkg::ERR_ACCESS_ABORTED;
          nxt_state = cedc_pkg::S_IDLE;
        end else begin
          // a read-only page only warns, the write still goes out
          nxt_warn = WARN_RO || ro_page;
          nxt_xreq = 1'b1;
          tmr_start = 1'b1;
          nxt_state = cedc_pkg::S_XFER;
        end
      end
      cedc_pkg::S_XFER: begin
        if (XFER_ACK) begin
          nxt_xreq = 1'b0;
          tmr_stop = 1'b1;
          if (XFER_STUCK) begin
            nxt_done = 1'b1;
            nxt_err = cedc_pkg::ERR_STUCK;
            nxt_state = cedc_pkg::S_IDLE;
          end else if (par_fault) begin
            nxt_done = 1'b1;
            nxt_err = cedc_pkg::ERR_PARITY;
            nxt_state = cedc_pkg::S_IDLE;
          end else if (fill_more) begin
            nxt_cnt = cnt_ff - 8'h01;
            nxt_addr = 22'(RES_ADDR + cedc_pkg::MEM_STEP[21:0]);
            nxt_state = cedc_pkg::S_CHECK;
          end else begin
            nxt_done = 1'b1;
            nxt_err = cedc_pkg::ERR_NONE;
            nxt_last_addr = RES_ADDR;
            nxt_last_space = RES_SPACE;
            nxt_state = cedc_pkg::S_IDLE;
            if (!XFER_WRITE) begin
              nxt_rdata = XFER_RDATA;
              nxt_last_data = XFER_RDATA;
            end
          end
        end else if (tmr_expired) begin
          // the access is dropped; the processor state is then unknown
          nxt_xreq = 1'b0;
          nxt_done = 1'b1;
          nxt_err = cedc_pkg::ERR_UNCERTAIN;
          nxt_state = cedc_pkg::S_IDLE;
        end
      end
      cedc_pkg::S_HALT: begin
        if (!CPU_RUNNING) begin
          nxt_halt = 1'b0;
          tmr_stop = 1'b1;
          nxt_done = 1'b1;
          nxt_err = cedc_pkg::ERR_NONE;
          nxt_state = cedc_pkg::S_IDLE;
        end else if (tmr_expired) begin
          nxt_halt = 1'b0;
          nxt_done = 1'b1;
          nxt_err = cedc_pkg::ERR_STOP_TIMEOUT;
          nxt_state = cedc_pkg::S_IDLE;
        end
      end
    endcase
  end

  cedc_timer #(.CYCLES(STOP_WAIT_CYCLES)) u_wait (
    .clk(CLK),
    .arst_n(ARST_N),
    .start(tmr_start),
    .stop(tmr_stop),
    .expired(tmr_expired)
  );

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_ff <= cedc_pkg::S_IDLE;
      cmd_ff <= cedc_pkg::CMD_EXAMINE;
      cnt_ff <= 8'h00;
      last_addr_ff <= 22'h000000;
      last_space_ff <= cedc_pkg::SP_PHYS;
      last_data_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      cnt_ff <= nxt_cnt;
      last_addr_ff <= nxt_last_addr;
      last_space_ff <= nxt_last_space;
      last_data_ff <= nxt_last_data;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUSY <= 1'b0;
      DONE <= 1'b0;
      ERR_CODE <= cedc_pkg::ERR_NONE;
      WARN_RO <= 1'b0;
      RES_ADDR <= 22'h000000;
      RES_SPACE <= cedc_pkg::SP_PHYS;
      RD_DATA <= 16'h0000;
      HALT_REQ <= 1'b0;
      XFER_REQ <= 1'b0;
      XFER_WRITE <= 1'b0;
      XFER_WDATA <= 16'h0000;
    end else begin
      BUSY <= (nxt_state != cedc_pkg::S_IDLE);
      DONE <= nxt_done;
      ERR_CODE <= nxt_err;
      WARN_RO <= nxt_warn;
      RES_ADDR <= nxt_addr;
      RES_SPACE <= nxt_space;
      RD_DATA <= nxt_rdata;
      HALT_REQ <= nxt_halt;
      XFER_REQ <= nxt_xreq;
      XFER_WRITE <= nxt_write;
      XFER_WDATA <= nxt_wdata;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  chk_must_stop: assert property (
    acc && CPU_RUNNING && REQ_CMD == cedc_pkg::CMD_EXAMINE && !syntax_bad
    |=> DONE && ERR_CODE == cedc_pkg::ERR_MUST_STOP && !XFER_REQ)
    else $error("running processor not refused");
  chk_switch_alias: assert property (
    acc && REQ_ARG == cedc_pkg::ARG_SWITCH
    |=> RES_ADDR == cedc_pkg::SWITCH_ADDR[21:0] && RES_SPACE == cedc_pkg::SP_PHYS)
    else $error("switch alias resolved wrong");
  chk_pstat_alias: assert property (
    acc && REQ_ARG == cedc_pkg::ARG_PSTAT
    |=> RES_ADDR == cedc_pkg::PSTAT_ADDR[21:0] && RES_SPACE == cedc_pkg::SP_PHYS)
    else $error("status alias resolved wrong");
  chk_greg_limit: assert property (
    acc && !CPU_RUNNING && REQ_CMD == cedc_pkg::CMD_EXAMINE &&
    REQ_ARG == cedc_pkg::ARG_GREG && !syntax_bad && dig_val > cedc_pkg::GREG_MAX
    |=> DONE && ERR_CODE == cedc_pkg::ERR_TOO_BIG)
    else $error("oversize register index accepted");
  chk_fill_limit: assert property (
    acc && !CPU_RUNNING && REQ_CMD == cedc_pkg::CMD_FILL && !syntax_bad &&
    REQ_COUNT > cedc_pkg::FILL_MAX |=> DONE && ERR_CODE == cedc_pkg::ERR_TOO_BIG)
    else $error("oversize fill count accepted");
  chk_bkpt_zero: assert property (
    acc && is_bkpt && REQ_ARG == cedc_pkg::ARG_OCTAL && !REQ_VIRT && !syntax_bad &&
    dig_val == 24'h000000 |=> DONE && ERR_CODE == cedc_pkg::ERR_BAD_BKPT)
    else $error("breakpoint at zero accepted");
  chk_micro_busy: assert property (
    acc && is_bkpt && REQ_ARG == cedc_pkg::ARG_SWITCH &&
    CPU_UADDR == cedc_pkg::MICRO_BUSY_ADDR
    |=> DONE && ERR_CODE == cedc_pkg::ERR_MICRO_STATE)
    else $error("breakpoint at busy micro address accepted");
  chk_mreg_ro: assert property (
    acc && !CPU_RUNNING && REQ_CMD == cedc_pkg::CMD_DEPOSIT && REQ_ARG == cedc_pkg::ARG_MREG
    && !syntax_bad && !data_big && dig_val <= cedc_pkg::MREG_MAX &&
    dig_val != cedc_pkg::MREG_WRITABLE |=> DONE && ERR_CODE == cedc_pkg::ERR_READ_ONLY)
    else $error("read-only register deposit accepted");
  chk_already_halt: assert property (
    acc && REQ_CMD == cedc_pkg::CMD_HALT && !CPU_RUNNING
    |=> DONE && ERR_CODE == cedc_pkg::ERR_ALREADY_HALTED && !HALT_REQ)
    else $error("halt of stopped processor not refused");
  chk_map_abort: assert property (
    state_ff == cedc_pkg::S_CHECK && unmapped
    |=> DONE && ERR_CODE == cedc_pkg::ERR_ACCESS_ABORTED ##1 !XFER_REQ)
    else $error("unmapped access not aborted");
  chk_ro_deposit: assert property (
    state_ff == cedc_pkg::S_CHECK && !unmapped && ro_page
    |=> XFER_REQ && XFER_WRITE && WARN_RO)
    else $error("read-only page deposit not carried out");
  chk_reuse_last: assert property (
    acc && REQ_ARG == cedc_pkg::ARG_LAST
    |=> RES_ADDR == $past(last_addr_ff) && RES_SPACE == $past(last_space_ff))
    else $error("last address not reused");

  cov_examine_ok: cover property (state_ff == cedc_pkg::S_XFER && XFER_ACK && !XFER_WRITE);
  cov_halt_ok: cover property (state_ff == cedc_pkg::S_HALT && !CPU_RUNNING);
  cov_fill_loop: cover property (state_ff == cedc_pkg::S_XFER ##1 state_ff == cedc_pkg::S_CHECK);
  cov_uncertain: cover property (DONE && ERR_CODE == cedc_pkg::ERR_UNCERTAIN);

endmodule

// *** cedc_cpu_model.sv ***
// processor-side model: halt handshake and access answers
`timescale 1ns/1ps
module cedc_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bench controls
  input wire logic go,
  input wire logic mute,
  input wire logic [1:0] lat,
  input wire logic [15:0] rdata,
  input wire logic par_bad,
  input wire logic stuck,
  // halt and access path
  input wire logic halt_req,
  input wire logic xfer_req,
  output logic running,
  output logic xfer_ack,
  output logic [15:0] xfer_rdata,
  output logic xfer_par_bad,
  output logic xfer_stuck
);
  logic [1:0] wait_ff;
  logic rest_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      running <= 1'b0;
      xfer_ack <= 1'b0;
      xfer_rdata <= 16'h0000;
      xfer_par_bad <= 1'b0;
      xfer_stuck <= 1'b0;
      wait_ff <= 2'h0;
      rest_ff <= 1'b0;
    end else begin
      xfer_ack <= 1'b0;
      xfer_par_bad <= 1'b0;
      xfer_stuck <= 1'b0;
      // data is not held outside the answer, so a late sample shows up
      xfer_rdata <= ~xfer_rdata;
      if (go) begin
        running <= 1'b1;
      end else if (halt_req && !mute) begin
        running <= 1'b0;
      end
      // rest one cycle after each answer: the request drops an edge late
      if (!xfer_req || rest_ff || mute) begin
        wait_ff <= lat;
        rest_ff <= 1'b0;
      end else if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end else begin
        xfer_ack <= 1'b1;
        xfer_rdata <= rdata;
        xfer_par_bad <= par_bad;
        xfer_stuck <= stuck;
        rest_ff <= 1'b1;
      end
    end
  end
endmodule

// *** testbench.sv ***
// self-checking bench for the examine/deposit checker
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
  logic clk, busy, done, warn_ro, cpu_running, halt_req, xfer_req, xfer_write;
  logic arst_n = 1'b0, req_valid = 1'b0, req_virt = 1'b0, par_en = 1'b0, page_ro = 1'b0;
  logic map_valid = 1'b1, go = 1'b0, mute = 1'b0, par_bad = 1'b0, stuck = 1'b0;
  logic xfer_ack, xfer_par_bad, xfer_stuck;
  cedc_pkg::cedc_cmd_t req_cmd = cedc_pkg::CMD_EXAMINE;
  cedc_pkg::cedc_arg_t req_arg = cedc_pkg::ARG_OCTAL;
  logic [23:0] req_digits = 24'h000000, d;
  logic [3:0] req_ndig = 4'h1;
  logic [17:0] req_data_digits = 18'h01234;
  logic [2:0] req_data_ndig = 3'h6;
  logic [15:0] req_count = 16'h0002, rdata = 16'h0000, rd_data, xfer_wdata, xfer_rdata, wlast;
  cedc_pkg::cedc_err_t err_code;
  logic [21:0] res_addr;
  cedc_pkg::cedc_space_t res_space;
  logic [7:0] cpu_uaddr = 8'h00;
  logic [1:0] lat = 2'h0;
  logic [31:0] seed = 32'h77476db2;
  int bad_count = 0, compares = 0, i;
  cedc_pkg::cedc_arg_t al [6] = '{cedc_pkg::ARG_SWITCH, cedc_pkg::ARG_PSTAT, cedc_pkg::ARG_PC,
    cedc_pkg::ARG_KSTACK, cedc_pkg::ARG_SSTACK, cedc_pkg::ARG_USTACK};
  logic [21:0] ax [6] = '{22'h3fff78, 22'h3ffffe, 22'h000007, 22'h000006, 22'h00000e, 22'h00000f};
  cedc_top #(.STOP_WAIT_CYCLES(20)) uut (
    .CLK(clk), .ARST_N(arst_n), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
    .REQ_ARG(req_arg), .REQ_DIGITS(req_digits), .REQ_NDIG(req_ndig), .REQ_VIRT(req_virt),
    .REQ_DATA_DIGITS(req_data_digits), .REQ_DATA_NDIG(req_data_ndig), .REQ_COUNT(req_count),
    .BUSY(busy), .DONE(done), .ERR_CODE(err_code), .WARN_RO(warn_ro), .RES_ADDR(res_addr),
    .RES_SPACE(res_space), .RD_DATA(rd_data), .CPU_RUNNING(cpu_running),
    .CPU_UADDR(cpu_uaddr), .PAR_EN(par_en), .MAP_VALID(map_valid), .PAGE_RO(page_ro),
    .HALT_REQ(halt_req), .XFER_REQ(xfer_req), .XFER_WRITE(xfer_write),
    .XFER_WDATA(xfer_wdata), .XFER_ACK(xfer_ack), .XFER_RDATA(xfer_rdata),
    .XFER_PAR_BAD(xfer_par_bad), .XFER_STUCK(xfer_stuck));
  cedc_cpu_model cpu (
    .clk(clk), .arst_n(arst_n), .go(go), .mute(mute), .lat(lat), .rdata(rdata),
    .par_bad(par_bad), .stuck(stuck), .halt_req(halt_req), .xfer_req(xfer_req),
    .running(cpu_running), .xfer_ack(xfer_ack), .xfer_rdata(xfer_rdata),
    .xfer_par_bad(xfer_par_bad), .xfer_stuck(xfer_stuck));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (xfer_req && xfer_write) begin
      wlast <= xfer_wdata;
    end
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // digits beyond the entered count read as zero
  function automatic logic [21:0] exp_addr(input logic [23:0] dg, input int n);
    logic [23:0] m;
    m = (24'h000001 << (3 * n)) - 24'h000001;
    return dg[21:0] & m[21:0];
  endfunction
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic ck(input cedc_pkg::cedc_cmd_t c, input cedc_pkg::cedc_arg_t a,
      input logic [23:0] dg, input logic [3:0] n, input logic v, input cedc_pkg::cedc_err_t e);
    int t;
    @(negedge clk);
    req_cmd = c;
    req_arg = a;
    req_digits = dg;
    req_ndig = n;
    req_virt = v;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin
      @(negedge clk);
      t++;
    end
    if (done !== 1'b1) begin
      bad_count++;
      close_out();
    end
    `CHK(err_code, e)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    for (i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      d = seed[23:0] & 24'h3fffff;
      rdata = seed[31:16];
      lat = seed[3:2];
      ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, d, 4'h8, 1'b0, cedc_pkg::ERR_NONE);
      `CHK(res_addr, exp_addr(d, 8))
      `CHK(rd_data, rdata)
    end
    rdata = 16'h0abc;
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, 24'hfff123, 4'h3, 1'b0,
      cedc_pkg::ERR_NONE);
    `CHK(res_addr, exp_addr(24'hfff123, 3))
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_LAST, 24'h0, 4'h0, 1'b0, cedc_pkg::ERR_NONE);
    `CHK(res_addr, 22'h000123)
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_INDIRECT, 24'h0, 4'h0, 1'b0,
      cedc_pkg::ERR_NONE);
    `CHK(res_addr, 22'h000abc)
    for (i = 0; i < 6; i++) begin
      ck(cedc_pkg::CMD_EXAMINE, al[i], 24'h000000, 4'h0, 1'b0, cedc_pkg::ERR_NONE);
      `CHK(res_addr, ax[i])
      `CHK(res_space, (i < 2) ? cedc_pkg::SP_PHYS : cedc_pkg::SP_GREG)
    end
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_GREG, 24'h10, 4'h2, 1'b0,
      cedc_pkg::ERR_TOO_BIG);
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_MREG, 24'ha, 4'h2, 1'b0,
      cedc_pkg::ERR_TOO_BIG);
    ck(cedc_pkg::CMD_DEPOSIT, cedc_pkg::ARG_MREG, 24'h5, 4'h1, 1'b0,
      cedc_pkg::ERR_READ_ONLY);
    ck(cedc_pkg::CMD_DEPOSIT, cedc_pkg::ARG_MREG, 24'h4, 4'h1, 1'b0, cedc_pkg::ERR_NONE);
    ck(cedc_pkg::CMD_BKPT, cedc_pkg::ARG_OCTAL, 24'h0, 4'h1, 1'b0, cedc_pkg::ERR_BAD_BKPT);
    ck(cedc_pkg::CMD_BKPT, cedc_pkg::ARG_GREG, 24'h1, 4'h1, 1'b0, cedc_pkg::ERR_BAD_BKPT);
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, 24'h10000, 4'h6, 1'b1,
      cedc_pkg::ERR_TOO_BIG);
    req_count = 16'h0100;
    ck(cedc_pkg::CMD_FILL, cedc_pkg::ARG_OCTAL, 24'h1000, 4'h4, 1'b0,
      cedc_pkg::ERR_TOO_BIG);
    // three words, last one lands two steps up
    req_count = 16'h0003;
    ck(cedc_pkg::CMD_FILL, cedc_pkg::ARG_OCTAL, 24'h400, 4'h4, 1'b0, cedc_pkg::ERR_NONE);
    `CHK(res_addr, 22'h000404)
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_NEXT, 24'h0, 4'h0, 1'b0, cedc_pkg::ERR_NONE);
    `CHK(res_addr, 22'h000406)
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_PREV, 24'h0, 4'h0, 1'b0, cedc_pkg::ERR_NONE);
    `CHK(res_addr, 22'h000404)
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_PC, 24'h0, 4'h0, 1'b0, cedc_pkg::ERR_MUST_STOP);
    cpu_uaddr = 8'h0d;
    ck(cedc_pkg::CMD_BKPT, cedc_pkg::ARG_SWITCH, 24'h0, 4'h0, 1'b0,
      cedc_pkg::ERR_MICRO_STATE);
    cpu_uaddr = 8'h00;
    mute = 1'b1;
    ck(cedc_pkg::CMD_HALT, cedc_pkg::ARG_PC, 24'h0, 4'h0, 1'b0, cedc_pkg::ERR_STOP_TIMEOUT);
    `CHK(halt_req, 1'b0)
    mute = 1'b0;
    ck(cedc_pkg::CMD_HALT, cedc_pkg::ARG_PC, 24'h0, 4'h0, 1'b0, cedc_pkg::ERR_NONE);
    ck(cedc_pkg::CMD_HALT, cedc_pkg::ARG_PC, 24'h0, 4'h0, 1'b0,
      cedc_pkg::ERR_ALREADY_HALTED);
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, 24'h7, 4'h0, 1'b0, cedc_pkg::ERR_SYNTAX);
    mute = 1'b1;
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, 24'h200, 4'h3, 1'b0,
      cedc_pkg::ERR_UNCERTAIN);
    mute = 1'b0;
    map_valid = 1'b0;
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, 24'h100, 4'h3, 1'b1,
      cedc_pkg::ERR_ACCESS_ABORTED);
    map_valid = 1'b1;
    page_ro = 1'b1;
    req_data_digits = 18'h3f1ff;
    req_data_ndig = 3'h3;
    ck(cedc_pkg::CMD_DEPOSIT, cedc_pkg::ARG_OCTAL, 24'h100, 4'h3, 1'b1, cedc_pkg::ERR_NONE);
    `CHK(warn_ro, 1'b1)
    `CHK(wlast, 16'h01ff)
    page_ro = 1'b0;
    par_en = 1'b1;
    par_bad = 1'b1;
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, 24'h300, 4'h3, 1'b0,
      cedc_pkg::ERR_PARITY);
    stuck = 1'b1;
    ck(cedc_pkg::CMD_EXAMINE, cedc_pkg::ARG_OCTAL, 24'h300, 4'h3, 1'b0,
      cedc_pkg::ERR_STUCK);
    close_out();
  end
endmodule
